// ### core/switch_vlan_queue_config.sv
// queue mapping and vlan entry configuration block with avalon-mm slave
//
// Summary of operation
// - map 00: priorities 0-2 low, 3 high
// - map 10 reset: 0-1 low, 2-3 high
// - map 11: only priority 0 low
// - map used only in two-queue mode
// - discard bit set: restrict to forwarding list
// - discard clear: single-destination frames unrestricted
// - discard clear, mirroring on: mirrored single-destination frame dropped
// - entry bit 31 valid flag, resets zero
// - forward-select 1: use entry port map
// - forward-select 0: use lookup-derived ports
// - entry bits 26:24 hold priority
// - entry bits 14:12 spanning instance index
// - entry bits 6:0 filter group id
// - entry register is table access path
`timescale 1ns/100ps
`default_nettype none
`include "switch_vlan_queue_consts.svh"

module switch_vlan_queue_config
(
	input wire logic clk,
	input wire logic srst,
	// avalon-mm slave
	input wire logic [11:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic [1:0] response,
	// queue selection path
	input wire logic twoQueueMode,
	input wire logic [1:0] regenPriority,
	output logic highQueue,
	// port membership path
	input wire logic singleDest,
	input wire logic mirrorEnable,
	input wire logic mirroredElsewhere,
	input wire logic [6:0] lookupPortMap,
	input wire logic [6:0] memberPortMap,
	input wire logic [6:0] vlanPortMap,
	output logic [6:0] egressPortMap,
	output logic frameDrop,
	// vlan entry fields and two-queue priority map
	output logic entryValid,
	output var switch_vlan_queue_pkg::fwd_source_t fwdSource,
	output logic [2:0] vlanPriority,
	output logic [2:0] spanning_instance_index,
	output logic [6:0] filter_group_id,
	output logic [1:0] two_queue_priority_map
);

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	config_bus_if cfg();
	logic [31:0] qmapCtrl;
	logic [31:0] vlanWord0;
	switch_vlan_queue_pkg::bus_state_t busState_ff;
	switch_vlan_queue_pkg::bus_state_t nxt_busState;
	logic [31:0] readdata_ff;
	logic [1:0] response_ff;

	vlan_queue_regs regs
	(
		.clk(clk),
		.srst(srst),
		.bus(cfg.store_side),
		.qmapCtrl(qmapCtrl),
		.vlanWord0(vlanWord0)
	);

	// a request waits one cycle, then is answered at the second edge
	always_comb
	begin
		nxt_busState = busState_ff;
		unique case (busState_ff)
			switch_vlan_queue_pkg::BUS_IDLE:
				if (read || write)
					nxt_busState = switch_vlan_queue_pkg::BUS_ANSWER;
			switch_vlan_queue_pkg::BUS_ANSWER:
				nxt_busState = switch_vlan_queue_pkg::BUS_IDLE;
		endcase
	end

	// bus phase register
	always_ff @(posedge clk)
	begin
		if (srst)
			busState_ff <= switch_vlan_queue_pkg::BUS_IDLE;
		else
			busState_ff <= nxt_busState;
	end

	// waitrequest low only in the answer cycle
	assign waitrequest = !(busState_ff == switch_vlan_queue_pkg::BUS_ANSWER);

	// store side access; write lands at the answer edge, unaligned hits nothing
	assign cfg.addr = address;
	assign cfg.wrData = writedata;
	assign cfg.byteEn = byteenable;
	assign cfg.writeEn = write && busState_ff == switch_vlan_queue_pkg::BUS_ANSWER && cfg.hit;

	// read data and response captured in the wait cycle
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			readdata_ff <= 32'h0000_0000;
			response_ff <= 2'h0;
		end
		else if (busState_ff == switch_vlan_queue_pkg::BUS_IDLE && (read || write))
		begin
			readdata_ff <= (read && cfg.hit) ? cfg.rdData : 32'h0000_0000;
			response_ff <= cfg.hit ? 2'h0 : 2'h3; // unmapped gives decode error
		end
	end

	assign readdata = readdata_ff;
	assign response = response_ff;

	// ----------------------------------------------------------------
	// field extraction
	// ----------------------------------------------------------------
	assign two_queue_priority_map = qmapCtrl[`QMAP_MAP_HI:`QMAP_MAP_LO];
	assign entryValid = vlanWord0[`VLAN_VALID_BIT];
	assign fwdSource = switch_vlan_queue_pkg::fwd_source_t'(vlanWord0[`VLAN_FWDSEL_BIT]);
	assign vlanPriority = vlanWord0[`VLAN_PRIO_HI:`VLAN_PRIO_LO];
	assign spanning_instance_index = vlanWord0[`VLAN_SPAN_HI:`VLAN_SPAN_LO];
	assign filter_group_id = vlanWord0[`VLAN_FID_HI:`VLAN_FID_LO];

	// ----------------------------------------------------------------
	// two-queue selection
	// ----------------------------------------------------------------
	function automatic switch_vlan_queue_pkg::queue_sel_t map_queue(input logic [1:0] code,
		input logic [1:0] prio);
		map_queue = switch_vlan_queue_pkg::QUEUE_LOW;
		unique case (code)
			`MAP_THREE_LOW:
				if (prio == 2'h3)
					map_queue = switch_vlan_queue_pkg::QUEUE_HIGH;
			`MAP_UNUSED:
				map_queue = switch_vlan_queue_pkg::QUEUE_LOW;
			`MAP_TWO_LOW:
				if (prio[1])
					map_queue = switch_vlan_queue_pkg::QUEUE_HIGH;
			`MAP_ONE_LOW:
				if (prio != 2'h0)
					map_queue = switch_vlan_queue_pkg::QUEUE_HIGH;
		endcase
	endfunction

	// map applies only in two-queue mode; otherwise the high bit passes through
	always_comb
	begin
		if (twoQueueMode)
			highQueue = map_queue(two_queue_priority_map, regenPriority)
				== switch_vlan_queue_pkg::QUEUE_HIGH;
		else
			highQueue = regenPriority[1];
	end

	// ----------------------------------------------------------------
	// egress port selection and membership restriction
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [6:0] candidate;
		logic limitMembers;
		candidate = lookupPortMap;
		limitMembers = qmapCtrl[`QMAP_DISCARD_BIT] || !singleDest;
		if (fwdSource == switch_vlan_queue_pkg::FWD_FROM_VLAN_MAP)
			candidate = vlanPortMap;
		egressPortMap = limitMembers ? (candidate & memberPortMap) : candidate;
		frameDrop = !qmapCtrl[`QMAP_DISCARD_BIT] && singleDest && mirrorEnable
			&& mirroredElsewhere;
		if (frameDrop)
			egressPortMap = 7'h00;
	end

endmodule

`default_nettype wire

// ### core/switch_vlan_queue_consts.svh
// constants for the queue mapping and vlan entry register block
`ifndef SWITCH_VLAN_QUEUE_CONSTS_SVH
`define SWITCH_VLAN_QUEUE_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define QMAP_CTRL_ADDR 12'h390
`define VLAN_WORD0_ADDR 12'h400

// ----------------------------------------------------------------
// queue_mapping_control fields
// ----------------------------------------------------------------
`define QMAP_MAP_HI 7
`define QMAP_MAP_LO 6
`define QMAP_RSV_HI 5
`define QMAP_RSV_LO 2
`define QMAP_DISCARD_BIT 1
`define QMAP_RSV0_BIT 0
`define QMAP_RW_MASK 32'h0000_00ff
`define QMAP_RESET 32'h0000_0082

// ----------------------------------------------------------------
// vlan_entry_word0 fields
// ----------------------------------------------------------------
`define VLAN_VALID_BIT 31
`define VLAN_FWDSEL_BIT 27
`define VLAN_PRIO_HI 26
`define VLAN_PRIO_LO 24
`define VLAN_SPAN_HI 14
`define VLAN_SPAN_LO 12
`define VLAN_FID_HI 6
`define VLAN_FID_LO 0
`define VLAN_RW_MASK 32'h8f00_707f
`define VLAN_RESET 32'h0000_0000

// ----------------------------------------------------------------
// two-queue map codes
// ----------------------------------------------------------------
`define MAP_THREE_LOW 2'h0
`define MAP_UNUSED 2'h1
`define MAP_TWO_LOW 2'h2
`define MAP_ONE_LOW 2'h3

`endif

// ### core/switch_vlan_queue_pkg.sv
// types shared by the queue mapping and vlan entry register block
package switch_vlan_queue_pkg;

	// forwarding source chosen by a vlan entry
	typedef enum logic
	{
		FWD_FROM_LOOKUP,
		FWD_FROM_VLAN_MAP
	} fwd_source_t;

	// egress queue chosen in two-queue mode
	typedef enum logic
	{
		QUEUE_LOW,
		QUEUE_HIGH
	} queue_sel_t;

	// bus slave phase
	typedef enum logic
	{
		BUS_IDLE,
		BUS_ANSWER
	} bus_state_t;

endpackage

// ### core/config_bus_if.sv
// register access carrier between the bus slave and the register store
`timescale 1ns/100ps
`default_nettype none

interface config_bus_if;
	logic writeEn;
	logic [11:0] addr;
	logic [31:0] wrData;
	logic [3:0] byteEn;
	logic [31:0] rdData;
	logic hit;

	modport slave_side (output writeEn, output addr, output wrData, output byteEn,
		input rdData, input hit);
	modport store_side (input writeEn, input addr, input wrData, input byteEn,
		output rdData, output hit);
endinterface

`default_nettype wire

// ### core/vlan_queue_regs.sv
// register store for queue mapping control and vlan entry word 0
`timescale 1ns/100ps
`default_nettype none
`include "switch_vlan_queue_consts.svh"

module vlan_queue_regs
(
	input wire logic clk,
	input wire logic srst,
	config_bus_if.store_side bus,
	output logic [31:0] qmapCtrl,
	output logic [31:0] vlanWord0
);

	// merge write data under byte enables and writable mask
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] lane;
		lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
		merge = (old & ~lane) | (wd & lane);
	endfunction

	logic [31:0] qmap_ff;
	logic [31:0] vlan_ff;

	// queue mapping control storage, reserved 5:2 and 0 just store
	always_ff @(posedge clk)
	begin
		if (srst)
			qmap_ff <= `QMAP_RESET;
		else if (bus.writeEn && bus.addr == `QMAP_CTRL_ADDR)
			qmap_ff <= merge(qmap_ff, bus.wrData, bus.byteEn, `QMAP_RW_MASK);
	end

	// vlan entry staging word, read-only holes kept at zero
	always_ff @(posedge clk)
	begin
		if (srst)
			vlan_ff <= `VLAN_RESET;
		else if (bus.writeEn && bus.addr == `VLAN_WORD0_ADDR)
			vlan_ff <= merge(vlan_ff, bus.wrData, bus.byteEn, `VLAN_RW_MASK);
	end

	// read mux and decode hit
	always_comb
	begin
		bus.hit = 1'b1;
		bus.rdData = 32'h0000_0000;
		if (bus.addr == `QMAP_CTRL_ADDR)
			bus.rdData = qmap_ff;
		else if (bus.addr == `VLAN_WORD0_ADDR)
			bus.rdData = vlan_ff;
		else
			bus.hit = 1'b0;
	end

	assign qmapCtrl = qmap_ff;
	assign vlanWord0 = vlan_ff;

endmodule

`default_nettype wire

// ### verif/svq_props.sv
// assertion checker for the queue mapping and vlan entry block
`timescale 1ns/100ps
`default_nettype none
module svq_props
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [11:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic [1:0] response,
	input wire logic twoQueueMode,
	input wire logic [1:0] regenPriority,
	input wire logic highQueue,
	input wire logic singleDest,
	input wire logic mirrorEnable,
	input wire logic mirroredElsewhere,
	input wire switch_vlan_queue_pkg::fwd_source_t fwdSource,
	input wire logic [6:0] lookupPortMap,
	input wire logic [6:0] memberPortMap,
	input wire logic [6:0] vlanPortMap,
	input wire logic [6:0] egressPortMap,
	input wire logic frameDrop,
	input wire logic entryValid,
	input wire logic [1:0] two_queue_priority_map
);
	// -----------------------------------------
	// bus, queue and forwarding properties
	// -----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	AST_RESET: assert property ($fell(srst) |-> two_queue_priority_map == 2'h2 && !entryValid)
		else $error("reset values wrong");
	AST_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("answer not one wait cycle");
	AST_UNMAP: assert property (read && !waitrequest && address != 12'h390
		&& address != 12'h400 |-> response == 2'h3 && readdata == 32'h0)
		else $error("unmapped read wrong");
	AST_QRSV: assert property (read && !waitrequest && address == 12'h390
		|-> response == 2'h0 && readdata[31:8] == 24'h0) else $error("reserved bits not zero");
	AST_MAPW: assert property (write && !waitrequest && address == 12'h390 && byteenable[0]
		|=> two_queue_priority_map == $past(writedata[7:6])) else $error("map not stored");
	AST_VALW: assert property (write && !waitrequest && address == 12'h400 && byteenable[3]
		|=> entryValid == $past(writedata[31])) else $error("valid not stored");
	AST_Q00: assert property (twoQueueMode && two_queue_priority_map == 2'h0
		|-> highQueue == (regenPriority == 2'h3)) else $error("map 00 queue wrong");
	AST_Q10: assert property (twoQueueMode && two_queue_priority_map == 2'h2
		|-> highQueue == regenPriority[1]) else $error("map 10 queue wrong");
	AST_Q11: assert property (twoQueueMode && two_queue_priority_map == 2'h3
		|-> highQueue == (regenPriority != 2'h0)) else $error("map 11 queue wrong");
	AST_QOFF: assert property (!twoQueueMode |-> highQueue == regenPriority[1])
		else $error("queue outside two-queue mode wrong");
	AST_FWD: assert property (!singleDest |-> egressPortMap ==
		((fwdSource ? vlanPortMap : lookupPortMap) & memberPortMap)) else $error("egress wrong");
	AST_DROP: assert property (frameDrop |-> singleDest && mirrorEnable && mirroredElsewhere
		&& egressPortMap == 7'h00) else $error("drop without mirrored single frame");
endmodule
bind switch_vlan_queue_config svq_props i_svq_props
(
	.clk(clk),
	.srst(srst),
	.address(address),
	.read(read),
	.write(write),
	.byteenable(byteenable),
	.writedata(writedata),
	.readdata(readdata),
	.waitrequest(waitrequest),
	.response(response),
	.twoQueueMode(twoQueueMode),
	.regenPriority(regenPriority),
	.highQueue(highQueue),
	.singleDest(singleDest),
	.mirrorEnable(mirrorEnable),
	.mirroredElsewhere(mirroredElsewhere),
	.fwdSource(fwdSource),
	.lookupPortMap(lookupPortMap),
	.memberPortMap(memberPortMap),
	.vlanPortMap(vlanPortMap),
	.egressPortMap(egressPortMap),
	.frameDrop(frameDrop),
	.entryValid(entryValid),
	.two_queue_priority_map(two_queue_priority_map)
);
`default_nettype wire

// ### verif/switch_vlan_queue_config_bench.sv
// self-checking bench for the queue mapping and vlan entry block
`timescale 1ns/100ps
`default_nettype none
module switch_vlan_queue_config_bench;
	logic clk = 0, srst = 1, read = 0, write = 0, twoQueueMode = 0, singleDest = 0;
	logic mirrorEnable = 0, mirroredElsewhere = 0, highQueue, waitrequest, frameDrop, entryValid;
	logic [11:0] address = 0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] writedata = 0, readdata, q;
	logic [1:0] regenPriority = 0, response, rsp, two_queue_priority_map;
	logic [6:0] lookupPortMap = 0, memberPortMap = 0, vlanPortMap = 0, egressPortMap;
	logic [6:0] filter_group_id;
	logic [2:0] vlanPriority, spanning_instance_index;
	switch_vlan_queue_pkg::fwd_source_t fwdSource;
	int failures = 0, num_checks = 0;
	// rows: map code, then high-queue flag per priority 3..0
	logic [5:0] rows [4] = '{6'h08, 6'h10, 6'h2c, 6'h3e};
	switch_vlan_queue_config i_switch_vlan_queue_config (.*);
	// ------------------------
	// clock and helper tasks
	// ------------------------
	initial
	begin
		forever #50 clk = ~clk;
	end
	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", s, e, g);
			failures++;
		end
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one bus access, raised after a rising edge, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		@(posedge clk);
		while (waitrequest !== 1'b0)
		begin
			n++;
			if (n > 20)
			begin
				failures++;
				final_report();
			end
			@(posedge clk);
		end
		q = readdata;
		rsp = response;
		read <= 0;
		write <= 0;
		@(posedge clk);
	endtask
	// frame flags: single destination, mirroring on, mirrored
	task automatic frame(input logic [2:0] f);
		@(posedge clk);
		{singleDest, mirrorEnable, mirroredElsewhere} <= f;
		@(negedge clk);
	endtask
	// ------------------------
	// main sequence
	// ------------------------
	initial
	begin
		repeat (20) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		bus(0, 12'h390, 0);
		chk("qmap reset", q, 32'h82);
		bus(0, 12'h400, 0);
		chk("entry reset", q, 32'h0);
		twoQueueMode <= 1;
		foreach (rows[i])
		begin
			bus(1, 12'h390, {24'h0, rows[i][5:4], 6'h02});
			for (int p = 0; p < 4; p++)
			begin
				regenPriority <= p[1:0];
				@(negedge clk);
				chk("highQueue", highQueue, rows[i][p]);
				@(posedge clk);
			end
		end
		twoQueueMode <= 0;
		regenPriority <= 2'h1;
		@(negedge clk);
		chk("highQueue off", highQueue, 0);
		@(posedge clk);
		bus(1, 12'h400, 32'hffffffff);
		bus(0, 12'h400, 0);
		chk("entry mask", q, 32'h8f00707f);
		chk("entry fields", {entryValid, fwdSource, vlanPriority, spanning_instance_index,
			filter_group_id}, 32'h7fff);
		bus(1, 12'h390, 32'hffffffff);
		bus(1, 12'h391, 0);
		bus(0, 12'h391, 0);
		chk("unmapped", {rsp, q[29:0]}, 32'hc0000000);
		bus(0, 12'h390, 0);
		chk("qmap mask", q, 32'hff);
		lookupPortMap <= 7'h0f;
		memberPortMap <= 7'h3c;
		vlanPortMap <= 7'h71;
		frame(3'b100);
		chk("egress", {frameDrop, egressPortMap}, 32'h30);
		frame(3'b111);
		chk("egress", {frameDrop, egressPortMap}, 32'h30);
		bus(1, 12'h400, 0);
		frame(3'b100);
		chk("egress", {frameDrop, egressPortMap}, 32'h0c);
		bus(1, 12'h390, 32'h80);
		frame(3'b110);
		chk("egress", {frameDrop, egressPortMap}, 32'h0f);
		frame(3'b111);
		chk("egress", {frameDrop, egressPortMap}, 32'h80);
		frame(3'b011);
		chk("egress", {frameDrop, egressPortMap}, 32'h0c);
		// mid-run reset returns both registers and the read path to reset values
		bus(1, 12'h390, 32'h0000_00ff);
		bus(1, 12'h400, 32'hffff_ffff);
		bus(0, 12'h400, 32'h0);
		srst <= 1;
		repeat (2) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		chk("waitrequest after reset", waitrequest, 32'h1);
		chk("readdata after reset", readdata, 32'h0);
		bus(0, 12'h390, 32'h0);
		chk("qmap after reset", q, 32'h82);
		bus(0, 12'h400, 32'h0);
		chk("entry after reset", q, 32'h0);
		// only the top byte lane is written
		byteenable <= 4'h8;
		bus(1, 12'h400, 32'hffff_ffff);
		byteenable <= 4'hf;
		bus(0, 12'h400, 32'h0);
		chk("entry byte lane", q, 32'h8f00_0000);
		final_report();
	end
endmodule
`default_nettype wire
